/* File: inc/gjw_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the port/watchdog bank
// Assumes: 10 MHz system clock
// Notes: Definitions only
`ifndef GJW_DEFINES_SVH
`define GJW_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define GJW_OFS_PORT 8'h00
`define GJW_OFS_WDCFG 8'h04
`define GJW_OFS_STAT 8'h08
`define GJW_OFS_MASK 8'h0C

// ==========================================================================
// Field positions
`define GJW_PORT_DIR_SEL_BIT 8
`define GJW_WD_JABBER_OFF 0
`define GJW_WD_IMM_UNJAB 1
`define GJW_WD_JAB_BYTESEL 2
`define GJW_WD_RSVD_ZERO 3
`define GJW_WD_RX_OFF 4
`define GJW_WD_RX_LONG 5
`define GJW_ST_RX_EXPIRE 0
`define GJW_ST_JABBER 1

// ==========================================================================
// Reset and read-back values
`define GJW_PORT_RESET 32'hFFFFFE00
`define GJW_WDCFG_RESET 32'hFFFFFEC8
`define GJW_OE_N_RESET 8'hFF

// ==========================================================================
// Timing: clock rate, byte and bit-time limits, times in microseconds
`define GJW_CLK_MHZ 10
`define GJW_RX_LIMIT_BYTES 12'hA00
`define GJW_JAB_BYTES 22'h000800
`define GJW_REL_LONG_BITS 6'h28
`define GJW_REL_SHORT_BITS 6'h10
`define GJW_JAB10_US 26000
`define GJW_JAB100_US 2600
`define GJW_UNJAB10_US 365000
`define GJW_UNJAB100_US 36500

`endif

/* File: inc/gjw_pkg.sv */
// Purpose: Types of the port/watchdog bank
// Assumes: Classic Wishbone, 32-bit data
// Notes: Constants live in gjw_defines.svh
package gjw_pkg;

  // ========================================================================
  // Bus carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } gjw_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gjw_wb_rsp_t;

  // ========================================================================
  // State machines
  typedef enum logic [1:0] {
    GJW_RX_PASS = 2'b00,
    GJW_RX_EXPIRED = 2'b01,
    GJW_RX_RELEASE = 2'b10
  } gjw_rx_t;

  typedef enum logic {
    GJW_TX_OK = 1'b0,
    GJW_TX_JABBED = 1'b1
  } gjw_tx_t;

endpackage : gjw_pkg

/* File: logic/gjw_regbank.sv */
// Purpose: General-purpose port and receive watchdog / transmit jabber timers
// Assumes: Wishbone slave on clk_i, carrier from a pin, MAC strobes on clk_i
// Notes: All outputs registered; ce_i low freezes everything except reset
//
// How it works
// R1 - Eight two-way port pins, one bit each
// R2 - Control bit set: write sets pin directions
// R3 - Reset makes every port pin an input
// R4 - Control clear: write drives output pins only
// R5 - Control clear: read returns pin levels
// R6 - Software writes zero to reserved bit
// R7 - Long release: rx re-enabled after 40 bits
// R8 - Short release: rx re-enabled after 16 bits
// R9 - Watchdog disable stops the receive counter
// R10 - Carrier beyond 2560 bytes times out
// R11 - Byte mode: cut transmit at 2048 bytes
// R12 - Time mode 10 Mb/s: cut at 26 ms
// R13 - Time mode 100 Mb/s: cut at 2.6 ms
// R14 - Immediate unjab releases transmit at once
// R15 - Delayed unjab 10 Mb/s: 365 ms
// R16 - Delayed unjab 100 Mb/s: 36.5 ms
// R17 - Jabber disable: no transmit cutoff
// R18 - Expired receiver discards data until release
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "gjw_defines.svh"
`default_nettype none

module gjw_regbank #(
  parameter int unsigned JAB10_CYC = `GJW_JAB10_US * `GJW_CLK_MHZ,
  parameter int unsigned JAB100_CYC = `GJW_JAB100_US * `GJW_CLK_MHZ,
  parameter int unsigned UNJAB10_CYC = `GJW_UNJAB10_US * `GJW_CLK_MHZ,
  parameter int unsigned UNJAB100_CYC = `GJW_UNJAB100_US * `GJW_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire gjw_pkg::gjw_wb_req_t wb_req_i,
  output var gjw_pkg::gjw_wb_rsp_t wb_rsp_o,
  input wire logic [7:0] gep_i,
  output logic [7:0] gep_o,
  output logic [7:0] gep_oe_n_o,
  input wire logic rx_carrier_i,
  input wire logic rx_byte_i,
  input wire logic bit_tick_i,
  input wire logic speed_100_i,
  input wire logic tx_active_i,
  input wire logic tx_byte_i,
  output logic rx_enable_o,
  output logic tx_enable_o,
  output logic irq_o
);
  import gjw_pkg::*;

  // ========================================================================
  // Elaboration check: timers must fit the 22-bit counter
  if (JAB10_CYC == 0 || JAB100_CYC == 0 || UNJAB10_CYC == 0 || UNJAB100_CYC == 0 ||
      JAB10_CYC >= (1 << 22) || JAB100_CYC >= (1 << 22) ||
      UNJAB10_CYC >= (1 << 22) || UNJAB100_CYC >= (1 << 22)) begin : g_chk
    $error("gjw_regbank: timer count out of range");
  end

  // ========================================================================
  // State of the whole block
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] gin_m;
    logic [7:0] gin;
    logic car_m;
    logic car;
    logic port_dir_select;
    logic [7:0] oe_n;
    logic [7:0] gout;
    logic [5:0] wdcfg;
    gjw_rx_t rx;
    logic [11:0] rx_bytes;
    logic [5:0] rx_bits;
    logic rx_en;
    gjw_tx_t tx;
    logic [21:0] tx_cnt;
    logic tx_en;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
  } gjw_state_t;

  gjw_state_t st_q;
  gjw_state_t st_d;

  logic req;
  logic commit;
  logic [7:0] wadr;
  logic eff_gpc;
  logic [7:0] port_rd;
  logic [5:0] rel_lim;
  logic [21:0] jab_lim;
  logic [21:0] unjab_lim;
  logic [1:0] ev;

  // ========================================================================
  // Bus decode and limit selection
  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign commit = req & st_q.ack;
  assign wadr = {wb_req_i.adr[7:2], 2'b00};
  assign eff_gpc = wb_req_i.sel[1] ? wb_req_i.dat[`GJW_PORT_DIR_SEL_BIT] : st_q.port_dir_select;
  // Direction view, or live levels merged with driven values
  assign port_rd = st_q.port_dir_select ? ~st_q.oe_n : ((st_q.gout & ~st_q.oe_n) | (st_q.gin & st_q.oe_n));
  assign rel_lim = st_q.wdcfg[`GJW_WD_RX_LONG] ? `GJW_REL_LONG_BITS : `GJW_REL_SHORT_BITS;
  assign jab_lim = st_q.wdcfg[`GJW_WD_JAB_BYTESEL] ? `GJW_JAB_BYTES :
                   (speed_100_i ? JAB100_CYC[21:0] : JAB10_CYC[21:0]);
  assign unjab_lim = speed_100_i ? UNJAB100_CYC[21:0] : UNJAB10_CYC[21:0];

  // ========================================================================
  // Next state
  always_comb begin
    st_d = st_q;
    ev = 2'b00;
    // Two-stage synchronisers for pins
    st_d.gin_m = gep_i;
    st_d.gin = st_q.gin_m;
    st_d.car_m = rx_carrier_i;
    st_d.car = st_q.car_m;

    // Bus: answer one cycle after the request, drop ack the cycle after
    st_d.ack = req & ~st_q.ack;
    if (req && !st_q.ack) begin
      case (wadr)
        `GJW_OFS_PORT: st_d.rdat = `GJW_PORT_RESET | {23'h000000, st_q.port_dir_select, port_rd}; // R5
        `GJW_OFS_WDCFG: st_d.rdat = (`GJW_WDCFG_RESET & 32'hFFFFFFC0) | {26'h0, st_q.wdcfg};
        `GJW_OFS_STAT: st_d.rdat = {30'h00000000, st_q.stat};
        `GJW_OFS_MASK: st_d.rdat = {30'h00000000, st_q.mask};
        default: st_d.rdat = 32'h00000000;
      endcase
    end

    // Register writes take effect on the acknowledged edge
    if (commit && wb_req_i.we) begin
      case (wadr)
        `GJW_OFS_PORT: begin
          if (wb_req_i.sel[1]) begin
            st_d.port_dir_select = wb_req_i.dat[`GJW_PORT_DIR_SEL_BIT];
          end
          if (wb_req_i.sel[0]) begin
            if (eff_gpc) begin
              st_d.oe_n = ~wb_req_i.dat[7:0]; // R2
            end else begin
              st_d.gout = (wb_req_i.dat[7:0] & ~st_q.oe_n) | (st_q.gout & st_q.oe_n); // R4
            end
          end
        end
        `GJW_OFS_WDCFG: begin
          // Reserved bit is stored for read-back but steers nothing
          if (wb_req_i.sel[0]) begin
            st_d.wdcfg = wb_req_i.dat[5:0]; // R6
          end
        end
        `GJW_OFS_MASK: begin
          if (wb_req_i.sel[0]) begin
            st_d.mask = wb_req_i.dat[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Receive watchdog
    case (st_q.rx)
      GJW_RX_PASS: begin
        st_d.rx_bits = 6'h00;
        if (!st_q.car || st_q.wdcfg[`GJW_WD_RX_OFF]) begin
          st_d.rx_bytes = 12'h000; // R9
        end else if (rx_byte_i) begin
          if (st_q.rx_bytes == `GJW_RX_LIMIT_BYTES - 12'h001) begin
            st_d.rx = GJW_RX_EXPIRED; // R10
            st_d.rx_bytes = 12'h000;
            ev[`GJW_ST_RX_EXPIRE] = 1'b1;
          end else begin
            st_d.rx_bytes = st_q.rx_bytes + 12'h001;
          end
        end
      end
      GJW_RX_EXPIRED: begin
        st_d.rx_bits = 6'h00;
        if (!st_q.car) begin
          st_d.rx = GJW_RX_RELEASE;
        end
      end
      GJW_RX_RELEASE: begin
        // Quiet interval restarts whenever carrier comes back
        if (st_q.car) begin
          st_d.rx = GJW_RX_EXPIRED;
          st_d.rx_bits = 6'h00;
        end else if (bit_tick_i) begin
          if (st_q.rx_bits == rel_lim - 6'h01) begin
            st_d.rx = GJW_RX_PASS; // R7 R8
            st_d.rx_bits = 6'h00;
          end else begin
            st_d.rx_bits = st_q.rx_bits + 6'h01;
          end
        end
      end
      default: begin
        st_d.rx = GJW_RX_PASS;
      end
    endcase
    st_d.rx_en = (st_d.rx == GJW_RX_PASS); // R18

    // Transmit jabber
    case (st_q.tx)
      GJW_TX_OK: begin
        if (!tx_active_i || st_q.wdcfg[`GJW_WD_JABBER_OFF]) begin
          st_d.tx_cnt = 22'h000000; // R17
        end else if (tx_byte_i || !st_q.wdcfg[`GJW_WD_JAB_BYTESEL]) begin
          if (st_q.tx_cnt == jab_lim - 22'h000001) begin
            st_d.tx = GJW_TX_JABBED; // R11 R12 R13
            st_d.tx_cnt = 22'h000000;
            ev[`GJW_ST_JABBER] = 1'b1;
          end else begin
            st_d.tx_cnt = st_q.tx_cnt + 22'h000001;
          end
        end
      end
      GJW_TX_JABBED: begin
        if (st_q.wdcfg[`GJW_WD_IMM_UNJAB] || st_q.wdcfg[`GJW_WD_JABBER_OFF]) begin
          st_d.tx = GJW_TX_OK; // R14
          st_d.tx_cnt = 22'h000000;
        end else if (st_q.tx_cnt == unjab_lim - 22'h000001) begin
          st_d.tx = GJW_TX_OK; // R15 R16
          st_d.tx_cnt = 22'h000000;
        end else begin
          st_d.tx_cnt = st_q.tx_cnt + 22'h000001;
        end
      end
      default: begin
        st_d.tx = GJW_TX_OK;
      end
    endcase
    st_d.tx_en = (st_d.tx == GJW_TX_OK);

    // Sticky status: read clears what was returned, a new event wins
    if (commit && !wb_req_i.we && wadr == `GJW_OFS_STAT) begin
      st_d.stat = st_q.stat & ~st_q.rdat[1:0];
    end
    st_d.stat = st_d.stat | ev;
    st_d.irq = |(st_d.stat & st_d.mask);
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.oe_n <= `GJW_OE_N_RESET; // R1 R3
      st_q.wdcfg <= 6'(`GJW_WDCFG_RESET);
      st_q.rx <= GJW_RX_PASS;
      st_q.rx_en <= 1'b1;
      st_q.tx <= GJW_TX_OK;
      st_q.tx_en <= 1'b1;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Outputs straight from the state register
  assign wb_rsp_o.ack = st_q.ack;
  assign wb_rsp_o.dat = st_q.rdat;
  assign gep_o = st_q.gout;
  assign gep_oe_n_o = st_q.oe_n;
  assign rx_enable_o = st_q.rx_en;
  assign tx_enable_o = st_q.tx_en;
  assign irq_o = st_q.irq;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);

  logic wr_port;
  logic rd_port;
  assign wr_port = commit & wb_req_i.we & (wadr == `GJW_OFS_PORT) & wb_req_i.sel[0];
  assign rd_port = req & ~st_q.ack & ~wb_req_i.we & (wadr == `GJW_OFS_PORT);

  sequence s_rx_quiet_done;
    st_q.rx == GJW_RX_RELEASE && !st_q.car && bit_tick_i && st_q.rx_bits == rel_lim - 6'h01;
  endsequence

  sequence s_rx_reopen;
    rx_enable_o && st_q.rx_bytes == 12'h000;
  endsequence

  sequence s_jab_hit;
    st_q.tx == GJW_TX_OK && tx_active_i && !st_q.wdcfg[`GJW_WD_JABBER_OFF] &&
    (tx_byte_i || !st_q.wdcfg[`GJW_WD_JAB_BYTESEL]) && st_q.tx_cnt == jab_lim - 22'h000001;
  endsequence

  a_reset_all_inputs: assert property ($fell(rst_i) |-> gep_oe_n_o == 8'hFF) // R3
    else $error("port pins not inputs after reset");
  a_dir_write_takes: assert property (wr_port && eff_gpc |=> gep_oe_n_o == ~$past(wb_req_i.dat[7:0])) // R2
    else $error("direction write lost");
  a_dir_keeps_out: assert property (wr_port && eff_gpc |=> $stable(gep_o)) // R2
    else $error("direction write moved outputs");
  a_data_write_outs: assert property (wr_port && !eff_gpc |=>
      gep_o == (($past(wb_req_i.dat[7:0]) & ~gep_oe_n_o) | ($past(gep_o) & gep_oe_n_o))) // R4
    else $error("data write touched input pins");
  a_port_read_levels: assert property (rd_port && !st_q.port_dir_select |=>
      wb_rsp_o.ack && wb_rsp_o.dat[7:0] == (($past(gep_o) & ~$past(gep_oe_n_o)) |
      ($past(st_q.gin) & $past(gep_oe_n_o)))) // R5
    else $error("port read value wrong");
  a_rx_long_cut: assert property (st_q.rx == GJW_RX_PASS && st_q.car && rx_byte_i &&
      !st_q.wdcfg[`GJW_WD_RX_OFF] && st_q.rx_bytes == `GJW_RX_LIMIT_BYTES - 12'h001
      |=> !rx_enable_o [*2]) // R10
    else $error("receive watchdog missed expiry");
  a_rx_off_holds: assert property (st_q.wdcfg[`GJW_WD_RX_OFF] && st_q.rx == GJW_RX_PASS
      |=> rx_enable_o && st_q.rx_bytes == 12'h000) // R9
    else $error("disabled watchdog still counted");
  a_rx_release_time: assert property (s_rx_quiet_done |=> s_rx_reopen) // R7 R8
    else $error("receive release late");
  a_rx_discard_blocked: assert property (st_q.rx != GJW_RX_PASS |-> !rx_enable_o) // R18
    else $error("receiver open while expired");
  a_rx_carrier_hold: assert property (st_q.rx != GJW_RX_PASS && st_q.car |=> !rx_enable_o) // R18
    else $error("receiver reopened under carrier");
  a_jab_cutoff: assert property (s_jab_hit |=> !tx_enable_o && st_q.stat[`GJW_ST_JABBER]) // R11 R12 R13
    else $error("jabber cutoff missed");
  a_jab_off_open: assert property (st_q.wdcfg[`GJW_WD_JABBER_OFF] && st_q.tx == GJW_TX_OK
      |=> tx_enable_o) // R17
    else $error("jabber cut while disabled");
  a_unjab_now: assert property (st_q.tx == GJW_TX_JABBED && st_q.wdcfg[`GJW_WD_IMM_UNJAB]
      |=> tx_enable_o) // R14
    else $error("immediate unjab late");
  a_unjab_delay: assert property (st_q.tx == GJW_TX_JABBED && !st_q.wdcfg[`GJW_WD_IMM_UNJAB] &&
      !st_q.wdcfg[`GJW_WD_JABBER_OFF] && st_q.tx_cnt < unjab_lim - 22'h000001
      |=> !tx_enable_o) // R15 R16
    else $error("transmit released early");

endmodule : gjw_regbank

`default_nettype wire

/* File: testbench/gjw_partner.sv */
// Purpose: Board and network side of the port/watchdog bank
// Assumes: One 10 MHz clock, board pins pulled to brd_i when undriven
// Notes: Bit-time tick only runs while the bench times a gap
`timescale 1ns/10ps
`default_nettype none

module gjw_partner (
  input wire logic clk_i,
  input wire logic tick_en_i,
  input wire logic [7:0] brd_i,
  input wire logic [7:0] gep_o_i,
  input wire logic [7:0] gep_oe_n_i,
  output logic [7:0] pin_o,
  output logic tick_o
);
  logic [1:0] div_q;

  // Wire level: device drives where its enable is low, board elsewhere
  assign pin_o = (gep_oe_n_i & brd_i) | (~gep_oe_n_i & gep_o_i);

  // One tick every four clocks, silent outside timed gaps
  always_ff @(posedge clk_i) begin
    div_q <= tick_en_i ? div_q + 2'h1 : 2'h0;
    tick_o <= tick_en_i && (div_q == 2'h3);
  end
endmodule : gjw_partner

`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench of the port/watchdog bank
// Assumes: Short jabber and unjab counts set by parameter
// Notes: Outputs sampled on the falling edge except bus replies, which wb samples on the rising; inputs driven on the rising
`timescale 1ns/10ps
`include "gjw_defines.svh"
`default_nettype none

module tb;
  import gjw_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  gjw_wb_req_t req = '0;
  gjw_wb_rsp_t rsp;
  logic [7:0] brd = 8'h00, pin, go, goe;
  logic car = 1'b0, rxb = 1'b0, txb = 1'b0, txa = 1'b0, spd = 1'b0, tick_en = 1'b0, ce = 1'b1;
  logic tick, rx_en, tx_en, irq;
  logic [31:0] rd;
  int error_cnt = 0, check_count = 0, cyc_cnt = 0;

  // ========================================================================
  // Clock, design, far side
  always #50 clk_i = ~clk_i;

  gjw_regbank #(.JAB10_CYC(40), .JAB100_CYC(20), .UNJAB10_CYC(60), .UNJAB100_CYC(30)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req), .wb_rsp_o(rsp),
    .gep_i(pin), .gep_o(go), .gep_oe_n_o(goe), .rx_carrier_i(car), .rx_byte_i(rxb),
    .bit_tick_i(tick), .speed_100_i(spd), .tx_active_i(txa), .tx_byte_i(txb),
    .rx_enable_o(rx_en), .tx_enable_o(tx_en), .irq_o(irq));

  gjw_partner model (.clk_i(clk_i), .tick_en_i(tick_en), .brd_i(brd), .gep_o_i(go),
    .gep_oe_n_i(goe), .pin_o(pin), .tick_o(tick));

  // ========================================================================
  // Shared tasks
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    @(posedge clk_i);
    chk(rsp.ack, 1'b0, "ack dropped");
  endtask : wb

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_n

  // Back-to-back byte strobes, one per clock
  task automatic pulses(input logic is_tx, input int n);
    @(posedge clk_i);
    if (is_tx) txb <= 1'b1;
    else rxb <= 1'b1;
    repeat (n) @(posedge clk_i);
    txb <= 1'b0;
    rxb <= 1'b0;
  endtask : pulses

  task automatic ticks(input int n);
    repeat (n) begin
      do @(posedge clk_i); while (tick !== 1'b1);
    end
  endtask : ticks

  task automatic lows(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk_i);
      if (tx_en !== 1'b1) c++;
    end
  endtask : lows

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    wb(1'b0, `GJW_OFS_PORT, 32'h0);
    chk(rd, 32'hFFFFFE00, "port reset");
    chk(goe, 8'hFF, "pins input");
    wb(1'b0, `GJW_OFS_WDCFG, 32'h0);
    chk(rd, 32'hFFFFFEC8, "config reset");
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("reset test done");
  endtask : t_reset

  task automatic t_port();
    @(posedge clk_i);
    brd <= 8'hC0;
    wb(1'b1, `GJW_OFS_PORT, 32'h0000010F);
    wait_n(2);
    chk(goe, 8'hF0, "direction");
    wb(1'b0, `GJW_OFS_PORT, 32'h0);
    chk(rd, 32'hFFFFFF0F, "direction read");
    wb(1'b1, `GJW_OFS_PORT, 32'h000000A5);
    wait_n(3);
    chk(go, 8'h05, "outputs only");
    chk(pin, 8'hC5, "wire level");
    wb(1'b0, `GJW_OFS_PORT, 32'h0);
    chk(rd, 32'hFFFFFEC5, "levels read");
    $display("port test done");
  endtask : t_port

  task automatic t_rx(input logic long_rel, input int rel);
    wb(1'b1, `GJW_OFS_WDCFG, {26'h0, long_rel, 5'h00});
    @(posedge clk_i);
    car <= 1'b1;
    wait_n(4);
    pulses(1'b0, 2559);
    wait_n(3);
    chk(rx_en, 1'b1, "rx below limit");
    pulses(1'b0, 1);
    wait_n(3);
    chk(rx_en, 1'b0, "rx expired");
    @(posedge clk_i);
    car <= 1'b0;
    wait_n(4);
    @(posedge clk_i);
    tick_en <= 1'b1;
    ticks(rel - 1);
    wait_n(2);
    chk(rx_en, 1'b0, "rx still off");
    ticks(1);
    wait_n(3);
    chk(rx_en, 1'b1, "rx released");
    @(posedge clk_i);
    tick_en <= 1'b0;
    $display("rx watchdog test done");
  endtask : t_rx

  task automatic t_irq();
    chk(irq, 1'b0, "masked event");
    wb(1'b1, `GJW_OFS_MASK, 32'h1);
    wait_n(2);
    chk(irq, 1'b1, "irq raised");
    wb(1'b0, `GJW_OFS_STAT, 32'h0);
    chk(rd[1:0], 2'h1, "status");
    wait_n(2);
    chk(irq, 1'b0, "irq cleared");
    wb(1'b0, `GJW_OFS_STAT, 32'h0);
    chk(rd[1:0], 2'h0, "status cleared");
    $display("irq test done");
  endtask : t_irq

  task automatic t_rxoff();
    wb(1'b1, `GJW_OFS_WDCFG, 32'h00000010);
    @(posedge clk_i);
    car <= 1'b1;
    wait_n(4);
    pulses(1'b0, 2700);
    wait_n(3);
    chk(rx_en, 1'b1, "watchdog off");
    @(posedge clk_i);
    car <= 1'b0;
    $display("rx off test done");
  endtask : t_rxoff

  task automatic t_jab();
    int c;
    wb(1'b1, `GJW_OFS_WDCFG, 32'h00000004);
    @(posedge clk_i);
    spd <= 1'b1;
    txa <= 1'b1;
    pulses(1'b1, 2047);
    wait_n(3);
    chk(tx_en, 1'b1, "tx below bytes");
    pulses(1'b1, 1);
    wait_n(3);
    chk(tx_en, 1'b0, "tx cut bytes");
    @(posedge clk_i);
    txa <= 1'b0;
    wait_n(20);
    chk(tx_en, 1'b0, "tx held 100");
    wait_n(15);
    chk(tx_en, 1'b1, "tx freed 100");
    wb(1'b1, `GJW_OFS_WDCFG, 32'h0);
    @(posedge clk_i);
    spd <= 1'b0;
    txa <= 1'b1;
    wait_n(34);
    chk(tx_en, 1'b1, "tx 10 early");
    wait_n(12);
    chk(tx_en, 1'b0, "tx 10 cut");
    @(posedge clk_i);
    txa <= 1'b0;
    wait_n(30);
    chk(tx_en, 1'b0, "tx held 10");
    wait_n(40);
    chk(tx_en, 1'b1, "tx freed 10");
    @(posedge clk_i);
    spd <= 1'b1;
    txa <= 1'b1;
    wait_n(15);
    chk(tx_en, 1'b1, "tx 100 early");
    wait_n(9);
    chk(tx_en, 1'b0, "tx 100 cut");
    @(posedge clk_i);
    txa <= 1'b0;
    wait_n(40);
    wb(1'b1, `GJW_OFS_WDCFG, 32'h00000006);
    @(posedge clk_i);
    txa <= 1'b1;
    pulses(1'b1, 2048);
    lows(6, c);
    chk(c > 0 && c < 3, 1'b1, "immediate unjab");
    wb(1'b1, `GJW_OFS_WDCFG, 32'h00000001);
    lows(60, c);
    chk(c, 32'h0, "jabber off");
    @(posedge clk_i);
    txa <= 1'b0;
    $display("jabber test done");
  endtask : t_jab

  // Enable low freezes the jabber count; both events remain in status
  task automatic t_ce();
    wb(1'b1, `GJW_OFS_WDCFG, 32'h0);
    @(posedge clk_i);
    spd <= 1'b1;
    txa <= 1'b1;
    ce <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce <= 1'b1;
    wait_n(15);
    chk(tx_en, 1'b1, "count frozen");
    wait_n(10);
    chk(tx_en, 1'b0, "count resumed");
    @(posedge clk_i);
    txa <= 1'b0;
    wb(1'b0, `GJW_OFS_STAT, 32'h0);
    chk(rd[1:0], 2'h3, "both events");
    $display("clock enable test done");
  endtask : t_ce

  // ========================================================================
  // Main sequence and hang guard
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_port();
    t_rx(1'b0, 16);
    t_irq();
    t_rx(1'b1, 40);
    t_rxoff();
    t_jab();
    t_ce();
    give_verdict();
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
endmodule : tb

`default_nettype wire
